// [rtl/stt_consts.vh]
// Constants shared by the system tick timer design files.
`ifndef STT_CONSTS_VH
`define STT_CONSTS_VH

// Widths.
`define STT_CNT_W 24
`define STT_PER_W 25
`define STT_ADDR_W 5
`define STT_DATA_W 32
`define STT_EVT_W 2

// Register byte offsets.
`define STT_OFF_CTRL 5'h00
`define STT_OFF_PERIOD 5'h04
`define STT_OFF_CURRENT 5'h08
`define STT_OFF_STATUS 5'h0C
`define STT_OFF_MASK 5'h10

// Control register fields.
`define STT_CTRL_EN 0
`define STT_CTRL_INTEN 1
`define STT_CTRL_PEND 2

// Status and mask fields.
`define STT_EVT_WRAP 0
`define STT_EVT_FORCE 1

// Reset values and one-step constants.
`define STT_RST_CNT 24'h000000
`define STT_RST_RELOAD 24'hFFFFFF
`define STT_RST_EVT 2'h0
`define STT_RST_DATA 32'h00000000
`define STT_CNT_ONE 24'h000001
`define STT_PER_ONE 25'h0000001

`endif

// [rtl/stt_counter.v]
// Down counter with reload storage, forced clear and wrap event.
`include "stt_consts.vh"

module stt_counter (
  input wire clk_sys,
  input wire rst,
  input wire enable,
  input wire reload_we,
  input wire [`STT_CNT_W-1:0] reload_wdata,
  input wire force_clear,
  output wire [`STT_CNT_W-1:0] count,
  output wire [`STT_CNT_W-1:0] reload,
  output wire wrap
);

  reg [`STT_CNT_W-1:0] count_q;
  reg [`STT_CNT_W-1:0] reload_q;
  reg forced_q;
  reg wrap_q;

  // Only the stored period changes; the running count is left alone.
  always @(posedge clk_sys) begin
    if (rst) begin
      reload_q <= `STT_RST_RELOAD;
    end else if (reload_we) begin
      reload_q <= reload_wdata;
    end
  end

  // A reload that follows a forced clear restarts the period silently.
  always @(posedge clk_sys) begin
    if (rst) begin
      count_q <= `STT_RST_CNT;
      forced_q <= 1'b0;
      wrap_q <= 1'b0;
    end else if (force_clear) begin
      count_q <= `STT_RST_CNT;
      forced_q <= 1'b1;
      wrap_q <= 1'b0;
    end else if (enable) begin
      if (count_q == `STT_RST_CNT) begin
        count_q <= reload_q;
        forced_q <= 1'b0;
        wrap_q <= ~forced_q;
      end else begin
        count_q <= count_q - `STT_CNT_ONE;
        wrap_q <= 1'b0;
      end
    end else begin
      wrap_q <= 1'b0;
    end
  end

  assign count = count_q;
  assign reload = reload_q;
  assign wrap = wrap_q;

endmodule // stt_counter

// [rtl/stt_irq.v]
// Tick pending flag with handler acknowledge, plus sticky status and mask.
`include "stt_consts.vh"

module stt_irq (
  input wire clk_sys,
  input wire rst,
  input wire enable,
  input wire tick_int_en,
  input wire tick_ack,
  input wire [`STT_EVT_W-1:0] evt_set,
  input wire status_rd_clr,
  input wire mask_we,
  input wire [`STT_EVT_W-1:0] mask_wdata,
  output wire tick_pending,
  output wire tick_irq,
  output wire [`STT_EVT_W-1:0] status,
  output wire [`STT_EVT_W-1:0] mask,
  output wire bus_irq
);

  reg pend_q;
  reg [`STT_EVT_W-1:0] status_q;
  reg [`STT_EVT_W-1:0] mask_q;

  // Entering the handler clears the pending tick; a new wrap wins.
  always @(posedge clk_sys) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (evt_set[`STT_EVT_WRAP]) begin
      pend_q <= 1'b1;
    end else if (tick_ack || !enable) begin
      pend_q <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `STT_EVT_W; i = i + 1) begin : g_evt
      always @(posedge clk_sys) begin
        if (rst) begin
          status_q[i] <= 1'b0;
        end else if (evt_set[i]) begin
          status_q[i] <= 1'b1;
        end else if (status_rd_clr) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (rst) begin
      mask_q <= `STT_RST_EVT;
    end else if (mask_we) begin
      mask_q <= mask_wdata;
    end
  end

  assign tick_pending = pend_q;
  assign tick_irq = pend_q & tick_int_en;
  assign status = status_q;
  assign mask = mask_q;
  assign bus_irq = |(status_q & mask_q);

endmodule // stt_irq

// [rtl/stt_top.v]
// System tick timer: Avalon-MM register slave around the tick counter.
`include "stt_consts.vh"

module stt_top (
  input wire clk_sys,
  input wire rst,
  input wire [`STT_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [`STT_DATA_W-1:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [`STT_DATA_W-1:0] avs_readdata,
  output wire avs_waitrequest,
  input wire tick_ack,
  output wire tick_irq,
  output wire bus_irq
);

  // Bus handshake state.
  reg ack_q;
  reg [`STT_DATA_W-1:0] rdata_q;

  // Control register.
  reg enable_q;
  reg inten_q;

  // Decode and strobes.
  wire req;
  wire done;
  wire wr_go;
  wire rd_go;
  wire sel_ctrl;
  wire sel_period;
  wire sel_current;
  wire sel_status;
  wire sel_mask;
  wire [`STT_DATA_W-1:0] bmask;

  // Counter side.
  wire [`STT_CNT_W-1:0] count;
  wire [`STT_CNT_W-1:0] reload;
  wire wrap;
  wire reload_we;
  wire force_clear;
  wire [`STT_PER_W-1:0] period_now;
  wire [`STT_PER_W-1:0] period_new;
  wire [`STT_CNT_W-1:0] reload_wdata;

  // Interrupt side.
  wire [`STT_EVT_W-1:0] evt_set;
  wire [`STT_EVT_W-1:0] status;
  wire [`STT_EVT_W-1:0] mask;
  wire tick_pending;
  wire mask_we;
  wire status_rd_clr;
  wire [`STT_DATA_W-1:0] ctrl_now;
  wire [`STT_DATA_W-1:0] ctrl_new;
  wire [`STT_DATA_W-1:0] mask_now;
  wire [`STT_DATA_W-1:0] mask_new;

  // One wait state: the first cycle of a request builds read data,
  // the second cycle drops waitrequest and commits the access.
  assign req = avs_read | avs_write;
  assign done = req & ack_q;
  assign wr_go = avs_write & ack_q;
  assign rd_go = avs_read & ack_q;
  assign avs_waitrequest = req & ~ack_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  assign sel_ctrl = (avs_address == `STT_OFF_CTRL);
  assign sel_period = (avs_address == `STT_OFF_PERIOD);
  assign sel_current = (avs_address == `STT_OFF_CURRENT);
  assign sel_status = (avs_address == `STT_OFF_STATUS);
  assign sel_mask = (avs_address == `STT_OFF_MASK);

  // Byte enables expand to a bit mask used for read-modify-write merges.
  assign bmask = {{8{avs_byteenable[3]}},
                  {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}},
                  {8{avs_byteenable[0]}}};

  // Control register: enable and interrupt enable, pending is read only.
  assign ctrl_now = {{(`STT_DATA_W-3){1'b0}}, tick_pending, inten_q, enable_q};
  assign ctrl_new = (avs_writedata & bmask) | (ctrl_now & ~bmask);

  always @(posedge clk_sys) begin
    if (rst) begin
      enable_q <= 1'b0;
      inten_q <= 1'b0;
    end else if (wr_go && sel_ctrl) begin
      enable_q <= ctrl_new[`STT_CTRL_EN];
      inten_q <= ctrl_new[`STT_CTRL_INTEN];
    end
  end

  // The period is held as period minus one so that 2^24 fits 24 bits.
  // A written 0 is outside the legal range and wraps to the largest period.
  assign period_now = {1'b0, reload} + `STT_PER_ONE;
  assign period_new = (avs_writedata[`STT_PER_W-1:0] & bmask[`STT_PER_W-1:0]) |
                      (period_now & ~bmask[`STT_PER_W-1:0]);
  assign reload_wdata = period_new[`STT_CNT_W-1:0] - `STT_CNT_ONE;
  assign reload_we = wr_go & sel_period;

  // Any write to the current value, whatever its data, forces a clear.
  assign force_clear = wr_go & sel_current;

  stt_counter u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(enable_q),
    .reload_we(reload_we),
    .reload_wdata(reload_wdata),
    .force_clear(force_clear),
    .count(count),
    .reload(reload),
    .wrap(wrap)
  );

  // Events: counter wrap and forced clear by software.
  assign evt_set = {force_clear, wrap};
  // An event that lands after the read data was captured holds off the clear, so none is lost.
  assign status_rd_clr = rd_go & sel_status & (rdata_q[`STT_EVT_W-1:0] == status);
  assign mask_now = {{(`STT_DATA_W-`STT_EVT_W){1'b0}}, mask};
  assign mask_new = (avs_writedata & bmask) | (mask_now & ~bmask);
  assign mask_we = wr_go & sel_mask;

  stt_irq u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(enable_q),
    .tick_int_en(inten_q),
    .tick_ack(tick_ack),
    .evt_set(evt_set),
    .status_rd_clr(status_rd_clr),
    .mask_we(mask_we),
    .mask_wdata(mask_new[`STT_EVT_W-1:0]),
    .tick_pending(tick_pending),
    .tick_irq(tick_irq),
    .status(status),
    .mask(mask),
    .bus_irq(bus_irq)
  );

  // Read data is captured in the wait cycle and held while it is presented.
  // Unmapped addresses read as zero and ignore writes.
  always @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= `STT_RST_DATA;
    end else if (avs_read && !ack_q) begin
      if (sel_ctrl) begin
        rdata_q <= ctrl_now;
      end else if (sel_period) begin
        rdata_q <= {{(`STT_DATA_W-`STT_PER_W){1'b0}}, period_now};
      end else if (sel_current) begin
        rdata_q <= {{(`STT_DATA_W-`STT_CNT_W){1'b0}}, count};
      end else if (sel_status) begin
        rdata_q <= {{(`STT_DATA_W-`STT_EVT_W){1'b0}}, status};
      end else if (sel_mask) begin
        rdata_q <= mask_now;
      end else begin
        rdata_q <= `STT_RST_DATA;
      end
    end else if (done) begin
      rdata_q <= rdata_q;
    end
  end

  assign avs_readdata = rdata_q;

endmodule // stt_top

// [verif/stt_ack_model.sv]
// Interrupt controller stand-in that enters the tick handler.
module stt_ack_model #(
  parameter int DLY = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick_irq,
  output logic tick_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  initial tick_ack = 1'b0;
  always @(posedge clk_sys) begin
    tick_ack <= 1'b0;
    if (rst || tick_irq !== 1'b1) begin
      cnt_q <= 0;
    end else if (cnt_q == DLY) begin
      tick_ack <= 1'b1;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule // stt_ack_model

// [verif/stt_top_monitor.sv]
// Assertions on the tick timer bus and interrupt outputs.
module stt_top_monitor (
  input wire clk_sys,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire tick_ack,
  input wire tick_irq,
  input wire bus_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire req = avs_read || avs_write;
  sequence s_wait; req && avs_waitrequest; endsequence
  sequence s_done; req && !avs_waitrequest; endsequence
  first_wait_a: assert property (req && !$past(req) |-> s_wait) else $error("no wait");
  one_wait_a: assert property (s_wait |=> s_done) else $error("wait not one cycle");
  idle_wait_a: assert property (!req |-> !avs_waitrequest) else $error("idle wait");
  irq_hold_a: assert property (tick_irq && !tick_ack && !avs_write |=> tick_irq)
    else $error("tick dropped");
  ack_clear_a: assert property (tick_irq && tick_ack |=> !tick_irq)
    else $error("ack kept tick");
  bus_hold_a: assert property (bus_irq && !req |=> bus_irq)
    else $error("bus irq dropped");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  rst_out_a: assert property (disable iff (1'b0) rst |=> !tick_irq && !bus_irq
    && avs_readdata == 32'h0) else $error("reset outputs");
endmodule // stt_top_monitor
bind stt_top stt_top_monitor u_mon (.clk_sys, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .tick_ack, .tick_irq, .bus_irq);

// [verif/testbench.sv]
// Self-checking bench for the system tick timer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] a; logic w; logic [31:0] d; logic [31:0] e;} stt_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire tick_ack;
  wire tick_irq;
  wire bus_irq;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int rise_n = 0;
  int gap = 0;
  int last = 0;
  int n;
  logic irq_p = 1'b0;
  logic [31:0] rd;
  logic [31:0] f;
  stt_row_t rows [10];
  stt_top dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tick_ack, .tick_irq, .bus_irq);
  stt_ack_model u_cpu (.clk_sys, .rst, .tick_irq, .tick_ack);
  always #4 clk_sys = ~clk_sys;
  task wrap_up;
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // The request stands until a rising edge sees waitrequest low; data is taken there.
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    irq_p <= tick_irq;
    if (tick_irq === 1'b1 && irq_p === 1'b0) begin
      rise_n <= rise_n + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    rows = '{'{5'h00, 1'b0, 32'h0, 32'h0}, '{5'h04, 1'b0, 32'h0, 32'h01000000},
      '{5'h0C, 1'b0, 32'h0, 32'h0}, '{5'h10, 1'b0, 32'h0, 32'h0},
      '{5'h04, 1'b1, 32'h01000000, 32'h01000000}, '{5'h04, 1'b1, 32'h1, 32'h1},
      '{5'h10, 1'b1, 32'hFFFFFFFF, 32'h3}, '{5'h14, 1'b1, 32'hFFFFFFFF, 32'h0},
      '{5'h00, 1'b1, 32'hFFFFFFFC, 32'h0}, '{5'h08, 1'b1, 32'h123, 32'h0}};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0);
      chk(rd, rows[i].e);
    end
    bus(5'h04, 1'b1, 32'h1000);
    bus(5'h08, 1'b1, 32'h0);
    bus(5'h00, 1'b1, 32'h1);
    bus(5'h00, 1'b1, 32'h0);
    bus(5'h08, 1'b0, 32'h0);
    f = rd;
    // Three enabled clocks pass: a silent reload to 0xFFF, then two decrements.
    chk(f, 32'h00000FFD);
    repeat (10) @(posedge clk_sys);
    bus(5'h04, 1'b1, 32'h6);
    bus(5'h08, 1'b0, 32'h0);
    chk(rd, f);
    bus(5'h00, 1'b1, 32'h1);
    bus(5'h08, 1'b0, 32'h0);
    // One enabled clock passes before the read data is captured, with no reload.
    chk(rd, 32'h00000FFC);
    bus(5'h08, 1'b1, 32'h0);
    bus(5'h00, 1'b1, 32'h3);
    n = rise_n + 2;
    while (rise_n < n) @(posedge clk_sys);
    chk(gap, 32'h6);
    bus(5'h00, 1'b1, 32'h0);
    n = rise_n;
    repeat (20) @(posedge clk_sys);
    chk(rise_n, n);
    chk(tick_irq, 32'h0);
    chk(bus_irq, 32'h1);
    bus(5'h10, 1'b1, 32'h0);
    chk(bus_irq, 32'h0);
    bus(5'h10, 1'b1, 32'h3);
    bus(5'h0C, 1'b0, 32'h0);
    chk(rd, 32'h3);
    bus(5'h0C, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(bus_irq, 32'h0);
    bus(5'h00, 1'b1, 32'h1);
    repeat (20) @(posedge clk_sys);
    chk(tick_irq, 32'h0);
    bus(5'h0C, 1'b0, 32'h0);
    chk(rd, 32'h1);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(5'h00, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(5'h04, 1'b0, 32'h0);
    chk(rd, 32'h01000000);
    chk(tick_irq, 32'h0);
    chk(bus_irq, 32'h0);
    wrap_up();
  end
endmodule // testbench
